// File: core/fsp_protect.sv
// Flash self-program protection: arbitrates CPU store-to-flash and
// load/fetch accesses against the busy region and the two lock fields.
// Assumes CPU, flash macro and fuse array run on sys_clk; AHB-Lite slave
// with a single master; flash read data is valid in the cycle of rd_req.
//
// Contract
// - Programming read-while-write region keeps CPU running.
// - Programming no-read-while-write region halts the CPU.
// - Any programming blocks reads of read-while-write region.
// - Busy flag reads one while region blocked.
// - Boot region lies inside no-read-while-write region.
// - Lock bits clear only by chip erase; here reset also reloads them to 4'hf.
// - General lock modes never gate self-programming.
// - App lock 10 blocks writes to application.
// - App lock 00/01 blocks boot loads of application.
// - App lock load-block masks interrupts in application.
// - Boot lock field guards boot region similarly.
// - Boot lock load-block masks interrupts in boot.
// - Reset vector follows the boot reset fuse.
// - CPU can never alter any fuse.
// - Store-to-flash starts only when executed from boot.
// - Read-enable write clears busy after programming.
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "fsp_map.svh"

module fsp_protect
  import fsp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // CPU store-to-flash request.
  input  wire logic        spm_req,
  input  wire logic        spm_op,
  input  wire logic [12:0] spm_addr,
  input  wire logic        spm_from_boot,
  // CPU fetch or load request.
  input  wire logic        rd_req,
  input  wire logic        rd_is_load,
  input  wire logic [12:0] rd_addr,
  input  wire logic        rd_from_boot,
  output logic             rd_grant,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  // CPU execution context.
  input  wire logic        exec_in_boot,
  input  wire logic        vectors_in_boot,
  output logic             irq_disable,
  output logic             cpu_halt,
  // Flash macro.
  input  wire logic [15:0] flash_rd_data,
  input  wire logic        flash_done,
  output logic             flash_start,
  output logic             flash_op,
  output logic [12:0]      flash_addr,
  // Fuses and external programming interface.
  input  wire logic [1:0]  boot_size_fuses,
  input  wire logic        boot_reset_fuse,
  input  wire logic        chip_erase,
  input  wire logic        ext_lock_wr,
  input  wire logic [3:0]  ext_lock_data,
  output logic [12:0]      reset_vector
);

  // ----------------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------------
  logic [12:0] boot_start;
  logic [3:0]  lock_reg, lock_next;
  logic [1:0]  app_region_lock;
  logic [1:0]  boot_region_lock;

  // Boot start from the size fuses, clamped to the upper region.
  // boot region clamp
  always_comb begin
    case (boot_size_fuses)
      2'b11:   boot_start = `FSP_BOOT_START_3;
      2'b10:   boot_start = `FSP_BOOT_START_2;
      2'b01:   boot_start = `FSP_BOOT_START_1;
      default: boot_start = `FSP_BOOT_START_0;
    endcase
    if (boot_start < `FSP_NO_READ_WHILE_WRITE_REGION_START) begin
      boot_start = `FSP_NO_READ_WHILE_WRITE_REGION_START;
    end
  end

  assign app_region_lock  = lock_reg[`FSP_LOCK_APP_LSB +: 2];
  assign boot_region_lock = lock_reg[`FSP_LOCK_BOOT_LSB +: 2];

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  logic        wr_pend_reg, wr_pend_next;
  logic [11:0] wr_ofs_reg, wr_ofs_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic        addr_phase;
  logic        wr_commit;
  logic        rre_wr;
  logic        clr_ref_wr;
  logic        busy_reg, busy_next;
  logic        ref_reg, ref_next;
  fsp_state_type state_reg, state_next;

  // A frozen clock enable stalls the bus rather than dropping a transfer.
  assign hreadyout  = clk_en;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_commit  = wr_pend_reg && clk_en;
  assign rre_wr     = wr_commit && (wr_ofs_reg == `FSP_CTRL_OFS) && hwdata[`FSP_CTRL_RRE];
  assign clr_ref_wr = wr_commit && (wr_ofs_reg == `FSP_CTRL_OFS)
                      && hwdata[`FSP_CTRL_CLR_REF];

  // Address phase capture and read data prepared for the data phase.
  // fuses read only
  always_comb begin
    wr_pend_next = addr_phase && hwrite;
    wr_ofs_next  = addr_phase ? haddr[11:0] : wr_ofs_reg;
    hrdata_next  = hrdata_reg;
    if (addr_phase && !hwrite) begin
      case (haddr[11:0])
        `FSP_STAT_OFS: hrdata_next = {28'h0000000, ref_reg, cpu_halt,
                                      state_reg != fsp_idle, busy_reg};
        `FSP_LOCK_OFS: hrdata_next = {28'h0000000, lock_reg};
        `FSP_FUSE_OFS: hrdata_next = {16'h0000, boot_size_fuses, boot_reset_fuse,
                                      boot_start};
        default:       hrdata_next = 32'h00000000;
      endcase
    end
  end

  // Bus registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 12'h000;
      hrdata_reg  <= 32'h00000000;
    end else if (clk_en) begin
      wr_pend_reg <= wr_pend_next;
      wr_ofs_reg  <= wr_ofs_next;
      hrdata_reg  <= hrdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Lock bits
  // ----------------------------------------------------------------------
  // Bits only move toward programmed (zero) except on chip erase or reset.
  // one-way lock bits
  always_comb begin
    lock_next = lock_reg;
    if (wr_commit && (wr_ofs_reg == `FSP_LOCK_OFS)) begin
      lock_next = lock_next & hwdata[3:0];
    end
    if (ext_lock_wr) begin
      lock_next = lock_next & ext_lock_data;
    end
    if (chip_erase) begin
      lock_next = `FSP_LOCK_MASK;
    end
  end

  // Lock register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_reg <= `FSP_LOCK_RST;
    end else if (clk_en) begin
      lock_reg <= lock_next;
    end
  end

  // ----------------------------------------------------------------------
  // Store-to-flash sequencer
  // ----------------------------------------------------------------------
  logic        tgt_boot;
  logic        wr_locked;
  logic        start_ok;
  logic        refused;
  logic        start_reg, start_next;
  logic        op_reg, op_next;
  logic [12:0] addr_reg, addr_next;

  assign tgt_boot = spm_addr >= boot_start;

  // Write lock: field bit 0 programmed blocks stores into that region.
  // application store lock
  assign wr_locked = tgt_boot ? !boot_region_lock[0] : !app_region_lock[0];

  assign start_ok = (state_reg == fsp_idle) && spm_req && spm_from_boot && !wr_locked;
  assign refused  = (state_reg == fsp_idle) && spm_req && !start_ok;

  // Next state, busy flag and refusal flag.
  always_comb begin
    state_next = state_reg;
    busy_next  = busy_reg;
    ref_next   = ref_reg;
    start_next = 1'b0;
    op_next    = op_reg;
    addr_next  = addr_reg;
    case (state_reg)
      fsp_idle: begin
        if (rre_wr) begin
          busy_next = 1'b0;
        end
        if (start_ok) begin
          start_next = 1'b1;
          op_next    = spm_op;
          addr_next  = spm_addr;
          busy_next  = 1'b1;
          state_next = (spm_addr < `FSP_NO_READ_WHILE_WRITE_REGION_START) ? fsp_rww_prog : fsp_no_read_while_write_region_prog;
        end
      end
      fsp_rww_prog, fsp_no_read_while_write_region_prog: begin
        if (flash_done) begin
          state_next = fsp_idle;
        end
      end
      default: state_next = fsp_idle;
    endcase
    // A new refusal in the clearing cycle wins.
    if (clr_ref_wr) begin
      ref_next = 1'b0;
    end
    if (refused) begin
      ref_next = 1'b1;
    end
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= fsp_idle;
      busy_reg  <= 1'b0;
      ref_reg   <= 1'b0;
      start_reg <= 1'b0;
      op_reg    <= 1'b0;
      addr_reg  <= 13'h0000;
    end else if (clk_en) begin
      state_reg <= state_next;
      busy_reg  <= busy_next;
      ref_reg   <= ref_next;
      start_reg <= start_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
    end
  end

  assign flash_start = start_reg;
  assign flash_op    = op_reg;
  assign flash_addr  = addr_reg;
  assign cpu_halt    = state_reg == fsp_no_read_while_write_region_prog;

  // ----------------------------------------------------------------------
  // Read arbitration and context outputs
  // ----------------------------------------------------------------------
  logic        rd_in_rww;
  logic        rd_in_boot;
  logic        rd_locked;
  logic        valid_reg, valid_next;
  logic [15:0] data_reg, data_next;
  logic        irq_reg, irq_next;
  logic [12:0] vec_reg, vec_next;

  assign rd_in_rww  = rd_addr < `FSP_NO_READ_WHILE_WRITE_REGION_START;
  assign rd_in_boot = rd_addr >= boot_start;

  // Load lock: field bit 1 programmed blocks cross-region loads.
  // boot loads of application
  assign rd_locked = rd_is_load
                     && ((rd_from_boot && !rd_in_boot && !app_region_lock[1])
                     || (!rd_from_boot && rd_in_boot && !boot_region_lock[1]));

  // Busy stays set until cleared by software, which guards stale reads.
  // lower region blocked
  assign rd_grant = rd_req && !(rd_in_rww && busy_reg) && !cpu_halt && !rd_locked;

  // Read data, interrupt mask and reset vector.
  always_comb begin
    valid_next = rd_req;
    data_next  = rd_grant ? flash_rd_data : 16'h0000;
    irq_next   = (!app_region_lock[1] && vectors_in_boot && !exec_in_boot)
                 || (!boot_region_lock[1] && !vectors_in_boot && exec_in_boot);
    vec_next   = boot_reset_fuse ? `FSP_RESET_APP : boot_start;
  end

  // Output registers.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      valid_reg <= 1'b0;
      data_reg  <= 16'h0000;
      irq_reg   <= 1'b0;
      vec_reg   <= `FSP_RESET_APP;
    end else if (clk_en) begin
      valid_reg <= valid_next;
      data_reg  <= data_next;
      irq_reg   <= irq_next;
      vec_reg   <= vec_next;
    end
  end

  assign rd_valid     = valid_reg;
  assign rd_data      = data_reg;
  assign irq_disable  = irq_reg;
  assign reset_vector = vec_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk iff clk_en); endclocking
  default disable iff (rst);

  sequence spm_launch_s;
    start_ok ##1 (flash_start && busy_reg);
  endsequence

  sequence rww_launch_s;
    start_ok && (spm_addr < `FSP_NO_READ_WHILE_WRITE_REGION_START);
  endsequence

  sequence no_read_while_write_region_launch_s;
    start_ok && (spm_addr >= `FSP_NO_READ_WHILE_WRITE_REGION_START);
  endsequence

  rww_no_halt_a: assert property (rww_launch_s |=> !cpu_halt [*2] or flash_done)
    else $error("CPU halted for lower region programming");

  no_read_while_write_region_halt_a: assert property (no_read_while_write_region_launch_s |=> cpu_halt)
    else $error("CPU not halted for upper region programming");

  rww_read_block_a: assert property (rd_req && rd_in_rww && busy_reg |-> !rd_grant)
    else $error("Read of blocked region granted");

  busy_launch_a: assert property (start_ok |-> spm_launch_s)
    else $error("Launch did not set busy and start");

  busy_hold_a: assert property (busy_reg && !rre_wr |=> busy_reg)
    else $error("Busy flag dropped without read enable");

  boot_inside_a: assert property (boot_start >= `FSP_NO_READ_WHILE_WRITE_REGION_START)
    else $error("Boot region outside upper region");

  lock_oneway_a: assert property (!chip_erase |=> (lock_reg & ~$past(lock_reg)) == 4'h0)
    else $error("Lock bit returned to unprogrammed");

  app_store_lock_a: assert property (spm_req && !tgt_boot && !app_region_lock[0] |=> !flash_start)
    else $error("Store into locked application region started");

  load_lock_a: assert property (rd_req && rd_locked |=> rd_valid && rd_data == 16'h0000)
    else $error("Locked load returned data");

  irq_mask_a: assert property ((!boot_region_lock[1] && !vectors_in_boot && exec_in_boot)
                               ##1 $stable(lock_reg) |-> irq_disable)
    else $error("Interrupts not masked in locked boot code");

  reset_vec_a: assert property (!boot_reset_fuse |=> reset_vector == $past(boot_start))
    else $error("Reset vector ignores boot reset fuse");

  app_spm_a: assert property (spm_req && !spm_from_boot |=> !flash_start)
    else $error("Store from application started programming");

  rre_clear_a: assert property (rre_wr && state_reg == fsp_idle && !start_ok |=> !busy_reg)
    else $error("Read enable did not clear busy");

endmodule : fsp_protect

// File: core/fsp_map.svh
// Address map, bit positions, reset values and region limits of the flash
// self-program protection block.
// Assumes a 13-bit flash word address (8K words) and 32-bit AHB-Lite data.
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// ------------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------------
`define FSP_CTRL_OFS      12'h000
`define FSP_STAT_OFS      12'h004
`define FSP_LOCK_OFS      12'h008
`define FSP_FUSE_OFS      12'h00c

// ------------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------------
`define FSP_CTRL_RRE      0
`define FSP_CTRL_CLR_REF  1
`define FSP_STAT_BUSY     0
`define FSP_STAT_PROG     1
`define FSP_STAT_HALT     2
`define FSP_STAT_REF      3
`define FSP_LOCK_APP_LSB  0
`define FSP_LOCK_BOOT_LSB 2
`define FSP_LOCK_RST      4'hf
`define FSP_LOCK_MASK     4'hf

// ------------------------------------------------------------------------
// Flash region limits (word addresses)
// ------------------------------------------------------------------------
`define FSP_NO_READ_WHILE_WRITE_REGION_START    13'h1c00
`define FSP_BOOT_START_3  13'h1f80
`define FSP_BOOT_START_2  13'h1f00
`define FSP_BOOT_START_1  13'h1e00
`define FSP_BOOT_START_0  13'h1c00
`define FSP_RESET_APP     13'h0000

`endif

// File: core/fsp_pkg.sv
// Types shared by the flash self-program protection block.
// Assumes fsp_map.svh sits on the include path.
package fsp_pkg;

  // Programming sequencer states.
  typedef enum logic [1:0] {
    fsp_idle      = 2'b00,
    fsp_rww_prog  = 2'b01,
    fsp_no_read_while_write_region_prog = 2'b10
  } fsp_state_type;

  // Store-to-flash operation kinds.
  typedef enum logic {
    fsp_op_erase = 1'b0,
    fsp_op_write = 1'b1
  } fsp_op_type;

endpackage : fsp_pkg

// File: test/fsp_flash_model.sv
// Flash macro model that faces the protection block.
// Assumes one sys_clk domain; the bench sets how long programming lasts.
`timescale 1ns/1ps

module fsp_flash_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  done_lat,
  input  wire logic        flash_start,
  input  wire logic        rd_req,
  input  wire logic [12:0] rd_addr,
  output logic             flash_done,
  output logic [15:0]      flash_rd_data
);
  logic [3:0] cnt_reg;
  logic       run_reg;

  // Word pattern follows the address; it is inverted when no read is asked.
  assign flash_rd_data = rd_req ? {3'h5, rd_addr} : ~{3'h5, rd_addr};

  // Counts the programming time and then gives one done pulse.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_reg    <= 1'b0;
      cnt_reg    <= 4'h0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= run_reg && (cnt_reg == 4'h0);
      if (flash_start) begin
        run_reg <= 1'b1;
        cnt_reg <= done_lat;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else begin
        run_reg <= 1'b0;
      end
    end
  end
endmodule : fsp_flash_model

// File: test/fsp_protect_bench.sv
// Self-checking bench for the flash self-program protection block.
// Assumes the flash model in its own file and a single AHB-Lite master.
`timescale 1ns/1ps
`include "fsp_map.svh"
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch %0t %s", $time, m); end end

module fsp_protect_bench;
  logic sys_clk, rst, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, boot_size_fuses;
  logic [2:0] hsize;
  logic spm_req, spm_op, spm_from_boot, rd_req, rd_is_load, rd_from_boot;
  logic [12:0] spm_addr, rd_addr, flash_addr, reset_vector;
  logic rd_grant, rd_valid, exec_in_boot, vectors_in_boot, irq_disable, cpu_halt;
  logic [15:0] rd_data, flash_rd_data;
  logic flash_done, flash_start, flash_op, boot_reset_fuse, chip_erase, ext_lock_wr;
  logic [3:0] ext_lock_data, done_lat;
  int n_mismatch, tests_run;
  logic [31:0] r;
  logic go;

  fsp_protect u_dut (.hready(hreadyout), .*);
  fsp_flash_model u_flash (.*);

  // Clock of 100 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------
  // Bus and request tasks
  // ---------------------------------------------------------------------
  // One single AHB-Lite transfer; read data is taken at the data-phase edge.
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
    `CHK(hresp, 1'b0, "response")
  endtask : ahb

  // Store-to-flash write request; go tells whether programming started.
  task automatic spm(input logic [12:0] a, input logic boot);
    @(posedge sys_clk);
    spm_req <= 1'b1; spm_addr <= a; spm_from_boot <= boot; spm_op <= 1'b1;
    @(posedge sys_clk);
    spm_req <= 1'b0;
    #1 go = flash_start;
    if (go) `CHK({flash_op, flash_addr}, {1'b1, a}, "launch target")
  endtask : spm

  // Waits for the flash to finish and lets the block return to idle.
  task automatic wait_done();
    do @(posedge sys_clk); while (flash_done !== 1'b1);
    @(posedge sys_clk);
    #1;
  endtask : wait_done

  // One fetch or load; checks grant, then the returned word.
  task automatic rd(input logic [12:0] a, input logic ld, input logic boot,
                    input logic g);
    @(posedge sys_clk);
    rd_req <= 1'b1; rd_addr <= a; rd_is_load <= ld; rd_from_boot <= boot;
    #1 `CHK(rd_grant, g, "grant")
    @(posedge sys_clk);
    rd_req <= 1'b0;
    #1 `CHK({rd_valid, rd_data}, {1'b1, g ? {3'h5, a} : 16'h0000}, "read data")
  endtask : rd

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  // Reset vector over all boot sizes, fuse register read-only, unmapped read.
  task automatic t_fuse();
    logic [12:0] st [4];
    st = '{13'h1c00, 13'h1e00, 13'h1f00, 13'h1f80};
    `CHK(reset_vector, 13'h0000, "vector app")
    for (int i = 0; i < 4; i++) begin
      boot_reset_fuse <= 1'b0; boot_size_fuses <= 2'(i);
      repeat (2) @(posedge sys_clk);
      #1 `CHK(reset_vector, st[i], "vector boot")
    end
    ahb(1'b1, `FSP_FUSE_OFS, 32'h0);
    ahb(1'b0, `FSP_FUSE_OFS, 32'h0);
    `CHK(r, 32'h0000df80, "fuse word")
    ahb(1'b0, 12'h010, 32'h0);
    `CHK(r, 32'h0, "unmapped")
    boot_reset_fuse <= 1'b1;
  endtask : t_fuse

  // Lower-region programming: CPU runs, lower region blocked until re-enable.
  task automatic t_rww();
    spm(13'h0100, 1'b1);
    `CHK({go, cpu_halt}, 2'b10, "rww start")
    // blocked-region fetch only as a refusal probe.
    rd(13'h0100, 1'b0, 1'b1, 1'b0);
    rd(13'h1d00, 1'b0, 1'b1, 1'b1);
    ahb(1'b1, `FSP_CTRL_OFS, 32'h1);
    ahb(1'b0, `FSP_STAT_OFS, 32'h0);
    `CHK(r[2:0], 3'b011, "busy prog")
    wait_done();
    ahb(1'b0, `FSP_STAT_OFS, 32'h0);
    `CHK(r[1:0], 2'b01, "busy kept")
    rd(13'h0100, 1'b0, 1'b1, 1'b0);
    ahb(1'b1, `FSP_CTRL_OFS, 32'h1);
    ahb(1'b0, `FSP_STAT_OFS, 32'h0);
    `CHK(r[0], 1'b0, "busy clear")
    rd(13'h0100, 1'b0, 1'b1, 1'b1);
  endtask : t_rww

  // Upper-region programming halts the CPU; stores from the application fail.
  task automatic t_no_read_while_write_region();
    spm(13'h1e00, 1'b1);
    `CHK({go, cpu_halt}, 2'b11, "halt")
    rd(13'h1d00, 1'b0, 1'b1, 1'b0);
    wait_done();
    `CHK(cpu_halt, 1'b0, "halt end")
    ahb(1'b1, `FSP_CTRL_OFS, 32'h1);
    spm(13'h1e00, 1'b0);
    `CHK(go, 1'b0, "app store")
    ahb(1'b0, `FSP_STAT_OFS, 32'h0);
    `CHK(r[3], 1'b1, "refused")
    ahb(1'b1, `FSP_CTRL_OFS, 32'h2);
    ahb(1'b0, `FSP_STAT_OFS, 32'h0);
    `CHK(r[3], 1'b0, "refused clear")
    @(posedge sys_clk);
    clk_en <= 1'b0;
    #1 `CHK(hreadyout, 1'b0, "stall")
    @(posedge sys_clk);
    clk_en <= 1'b1;
  endtask : t_no_read_while_write_region

  // One lock value on one field: bits only fall, loads, stores and masking.
  task automatic t_lock(input logic boot, input logic [1:0] v);
    logic [3:0]  w;
    logic [12:0] a;
    w = boot ? {v, 2'b11} : {2'b11, v};
    a = boot ? 13'h1f80 : 13'h0200;
    @(posedge sys_clk);
    chip_erase <= 1'b1; exec_in_boot <= boot; vectors_in_boot <= ~boot;
    @(posedge sys_clk);
    chip_erase <= 1'b0;
    ahb(1'b1, `FSP_LOCK_OFS, {28'h0, w});
    ahb(1'b1, `FSP_LOCK_OFS, 32'hf);
    ahb(1'b0, `FSP_LOCK_OFS, 32'h0);
    `CHK(r[3:0], w, "lock value")
    `CHK(irq_disable, ~v[1], "irq mask")
    rd(a, 1'b1, ~boot, v[1]);
    spm(a, 1'b1);
    `CHK(go, v[0], "store gate")
    if (go) wait_done();
    ahb(1'b1, `FSP_CTRL_OFS, 32'h3);
  endtask : t_lock

  // ---------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------------
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (6000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    logic [1:0] vals [4];
    vals = '{2'b11, 2'b10, 2'b00, 2'b01};
    rst = 1'b1; clk_en = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; spm_req = 1'b0; spm_op = 1'b0;
    spm_addr = 13'h0; spm_from_boot = 1'b0; rd_req = 1'b0; rd_is_load = 1'b0;
    rd_addr = 13'h0; rd_from_boot = 1'b0; exec_in_boot = 1'b0;
    vectors_in_boot = 1'b0; boot_size_fuses = 2'h3; boot_reset_fuse = 1'b1;
    chip_erase = 1'b0; ext_lock_wr = 1'b0; ext_lock_data = 4'hf; done_lat = 4'hc;
    n_mismatch = 0; tests_run = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1 t_fuse();
    t_rww();
    t_no_read_while_write_region();
    done_lat <= 4'h1;
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 4; i++) t_lock(b[0], vals[i]);
    end
    @(posedge sys_clk);
    ext_lock_wr <= 1'b1; ext_lock_data <= 4'he;
    @(posedge sys_clk);
    ext_lock_wr <= 1'b0;
    ahb(1'b0, `FSP_LOCK_OFS, 32'h0);
    `CHK(r[3:0], 4'h6, "ext lock")
    final_report();
  end
endmodule : fsp_protect_bench
